// >>> inc/pcl_pkg.sv
/*
 * pcl_pkg: constants for the panel close-inhibit and profile logic.
 * Assumes a 10 MHz system clock and a 32-bit Avalon-MM register port.
 */
package pcl_pkg;
   // clock and times, figures as printed
   localparam longint unsigned CLK_HZ = 64'd10000000;
   localparam longint unsigned EDIT_WIN_S = 64'd10;
   localparam longint unsigned BLANK_MIN = 64'd10;
   localparam longint unsigned CLFAIL_S = 64'd5;
   localparam longint unsigned EDIT_WIN_CYC = EDIT_WIN_S * CLK_HZ;
   localparam longint unsigned BLANK_CYC = BLANK_MIN * 64'd60 * CLK_HZ;
   localparam longint unsigned CLFAIL_CYC = CLFAIL_S * CLK_HZ;

   // register byte offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_CMD = 4'h4;
   localparam logic [3:0] OFS_STATUS = 4'h8;
   localparam logic [3:0] OFS_ALARM = 4'hC;

   // ctrl fields and reset value
   localparam int CTRL_PWRSAVE = 0;
   localparam int CTRL_INRUSH_EN = 1;
   localparam int CTRL_INRUSH_BLK = 2;
   localparam int CTRL_FASTDIS = 3;
   localparam logic [3:0] CTRL_RST = 4'h3;

   // serial command fields (write only)
   localparam int CMD_LIVE_SET = 0;
   localparam int CMD_LIVE_CLR = 1;
   localparam int CMD_EARTH_SET = 2;
   localparam int CMD_EARTH_CLR = 3;
   localparam int CMD_RECL_SET = 4;
   localparam int CMD_RECL_CLR = 5;
   localparam int CMD_CLOSE = 6;
   localparam int CMD_PROF_WR = 7;
   localparam int CMD_PROF_LSB = 8;

   // alarm register: write one to clear
   localparam int ALM_CLFAIL = 0;

   // status fields
   localparam int ST_LIVE = 0;
   localparam int ST_REQ_LSB = 1;
   localparam int ST_EARTH = 4;
   localparam int ST_RECL = 5;
   localparam int ST_REMLK = 6;
   localparam int ST_PROF_LSB = 7;
   localparam int ST_CLFAIL = 9;
   localparam int ST_LOCKOUT = 10;
   localparam int ST_BRK = 11;
   localparam int ST_EDIT = 12;
   localparam int ST_INRUSH = 13;
   localparam int ST_PEND = 14;
   localparam int ST_BLANK = 15;

   localparam logic [1:0] PROF_NORMAL = 2'h0;
endpackage

// >>> rtl/pcl_timer.sv
/*
 * pcl_timer: reloadable one-shot countdown with a one-cycle done pulse.
 * Assumes an asynchronous active-low reset and a shared clock enable.
 */
`timescale 1ns/1ns
module pcl_timer #(
   parameter longint unsigned LEN = 64'd10,
   parameter int W = $clog2(LEN + 1)
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic start,
   input wire logic stop,
   output logic busy,
   output logic done
);
   localparam logic [W-1:0] LOAD = W'(LEN - 64'd1);
   logic [W-1:0] cnt_r;

   initial begin
      if (LEN < 64'd1) begin
         $error("pcl_timer: LEN must be at least one cycle");
      end
   end

   // restart wins over stop so a fresh start is never lost
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else if (ce) begin
         done <= 1'b0;
         if (start) begin
            cnt_r <= LOAD;
            busy <= 1'b1;
         end else if (stop) begin
            busy <= 1'b0;
         end else if (busy) begin
            if (cnt_r == '0) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_r <= cnt_r - 1'b1;
            end
         end
      end
   end
endmodule // pcl_timer

// >>> rtl/pcl_panel.sv
/*
 * pcl_panel: front-panel supervisory logic of a recloser controller:
 * live-work close inhibit, close interlock, trip/close buttons, edit window,
 * function keys and settings-group selection, with an Avalon-MM slave.
 * Assumes panel and supervisory inputs are asynchronous levels, already debounced.
 */
// Our own choices: register access over Avalon-MM and the register offsets.
// Notes on behaviour
// - live-work inhibit suppresses every close from any source
// - turning the inhibit on never trips the breaker by itself
// - inhibit forces one trip to lockout on faster of definite/fast curve
// - inhibit overrides inrush restraint, reclosing inhibit and fast-trip disable
// - inhibit is OR of panel, serial and supervisory requests
// - each request is cleared only by the source that set it
// - inhibit LED lit whenever inhibit active
// - power save blanks LEDs after ten idle minutes, except inhibit LED
// - interlock removed: no close at all, trips still work
// - close with interlock out alarms after five seconds; restore first closes
// - trip button opens breaker and locks out, independent of processor
// - close button homes the sequence and closes the breaker
// - latched close-failure alarm blocks closing until reset
// - close from lockout starts inrush restraint if enabled and unblocked
// - close while breaker already closed does not start inrush restraint
// - function LEDs show function state whatever the source
// - earth-trip block from serial, discrete, software or panel
// - reclosing inhibit suppresses auto reclose, curve unchanged
// - remote lockout rejects rear serial and discrete commands only; their live-work set and clear requests are still taken
// - remote lockout changes only via edit key then its key
// - four settings groups, normal when no alternate set
// - edit then alternate key selects; same key deselects; remote may too
// - edit window expiry leaves all settings unchanged
`timescale 1ns/1ns
module pcl_panel #(
   parameter longint unsigned EDIT_CYC = pcl_pkg::EDIT_WIN_CYC,
   parameter longint unsigned BLANK_CYC = pcl_pkg::BLANK_CYC,
   parameter longint unsigned CLFAIL_CYC = pcl_pkg::CLFAIL_CYC
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic live_switch,
   input wire logic edit_key,
   input wire logic earth_key,
   input wire logic recl_key,
   input wire logic remlock_key,
   input wire logic [2:0] prof_key,
   input wire logic close_btn,
   input wire logic trip_btn,
   input wire logic sc_live_set,
   input wire logic sc_live_clr,
   input wire logic sc_earth_set,
   input wire logic sc_earth_clr,
   input wire logic sc_recl_set,
   input wire logic sc_recl_clr,
   input wire logic sc_close,
   input wire logic interlock_in,
   input wire logic breaker_closed,
   output logic close_cmd,
   output logic trip_cmd,
   output logic seq_home,
   output logic lockout,
   output logic one_trip_lockout,
   output logic composite_curve,
   output logic inrush_restraint_protection,
   output logic reclose_block,
   output logic fast_trip_disable,
   output logic earth_block,
   output logic [1:0] active_group,
   output logic remote_lockout,
   output logic led_live,
   output logic led_earth,
   output logic led_recl,
   output logic led_remlock,
   output logic [2:0] led_prof,
   output logic led_alarm,
   output logic led_lockout
);
   localparam int NP = 19;

   initial begin
      if (EDIT_CYC < 64'd1 || BLANK_CYC < 64'd1 || CLFAIL_CYC < 64'd1) begin
         $error("pcl_panel: timer lengths must be at least one cycle");
      end
   end

   // reset release through two flops
   logic [1:0] rst_sync_r;
   logic rst_n;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_r <= 2'h0;
      end else if (ce) begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // pins pass two flops; a third stage gives rising edges
   logic [NP-1:0] pin_raw, s1_r, s2_r, s3_r, rise;
   assign pin_raw = {breaker_closed, interlock_in, sc_close, sc_recl_clr, sc_recl_set, sc_earth_clr,
                     sc_earth_set, sc_live_clr, sc_live_set, trip_btn, close_btn, prof_key,
                     remlock_key, recl_key, earth_key, edit_key, live_switch};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else if (ce) begin
         s1_r <= pin_raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   assign rise = s2_r & ~s3_r;

   logic live_sw_s, brk_s, ilock_s;
   logic ed_p, earth_p, recl_p, reml_p, close_p, trip_p;
   logic [2:0] prof_p;
   logic scl_set, scl_clr, sce_set, sce_clr, scr_set, scr_clr, sc_close_p;
   assign live_sw_s = s2_r[0];
   assign ed_p = rise[1];
   assign earth_p = rise[2];
   assign recl_p = rise[3];
   assign reml_p = rise[4];
   assign prof_p = rise[7:5];
   assign close_p = rise[8];
   assign trip_p = rise[9];
   assign scl_set = rise[10];
   assign scl_clr = rise[11];
   assign sce_set = rise[12];
   assign sce_clr = rise[13];
   assign scr_set = rise[14];
   assign scr_clr = rise[15];
   assign sc_close_p = rise[16];
   assign ilock_s = s2_r[17];
   assign brk_s = s2_r[18];

   // avalon slave: one wait state, then the access completes
   logic [31:0] wmask, wd;
   logic acc, wr_go;
   logic [3:0] ctrl_r;
   assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
                   {8{avs_byteenable[0]}}};
   assign wd = avs_writedata & wmask;
   assign acc = (avs_read | avs_write) & avs_waitrequest;
   assign wr_go = avs_write & ~avs_waitrequest;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
      end else if (ce) begin
         avs_waitrequest <= ~acc;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= pcl_pkg::CTRL_RST;
      end else if (ce && wr_go && avs_address == pcl_pkg::OFS_CTRL) begin
         ctrl_r <= (ctrl_r & ~wmask[3:0]) | wd[3:0];
      end
   end

   logic cmd_wr, alm_wr;
   assign cmd_wr = wr_go && avs_address == pcl_pkg::OFS_CMD;
   assign alm_wr = wr_go && avs_address == pcl_pkg::OFS_ALARM;

   // remote lockout gates rear serial and discrete commands, except the live-work set and clear requests
   logic rem_ok;
   assign rem_ok = ~remote_lockout;

   logic req_panel, req_serial_r, req_scada_r, live_on;
   assign req_panel = live_sw_s;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_serial_r <= 1'b0;
      end else if (ce) begin
         if (cmd_wr && wd[pcl_pkg::CMD_LIVE_SET]) begin
            req_serial_r <= 1'b1;
         end else if (cmd_wr && wd[pcl_pkg::CMD_LIVE_CLR]) begin
            req_serial_r <= 1'b0;
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_scada_r <= 1'b0;
      end else if (ce) begin
         if (scl_set) begin
            req_scada_r <= 1'b1;
         end else if (scl_clr) begin
            req_scada_r <= 1'b0;
         end
      end
   end
   assign live_on = req_panel | req_serial_r | req_scada_r;

   // edit window
   logic edit_busy, edit_done, fkey, edit_take;
   assign fkey = earth_p | recl_p | reml_p | (|prof_p);
   assign edit_take = edit_busy & fkey;
   pcl_timer #(.LEN(EDIT_CYC)) u_edit (
      .clk(clk), .rst_n(rst_n), .ce(ce), .start(ed_p), .stop(edit_take),
      .busy(edit_busy), .done(edit_done)
   );

   // earth block from any source, set wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         earth_block <= 1'b0;
      end else if (ce) begin
         if ((edit_take && earth_p && !earth_block) || (rem_ok && (sce_set
             || (cmd_wr && wd[pcl_pkg::CMD_EARTH_SET])))) begin
            earth_block <= 1'b1;
         end else if ((edit_take && earth_p) || (rem_ok && (sce_clr
             || (cmd_wr && wd[pcl_pkg::CMD_EARTH_CLR])))) begin
            earth_block <= 1'b0;
         end
      end
   end

   logic recl_inh_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         recl_inh_r <= 1'b0;
      end else if (ce) begin
         if ((edit_take && recl_p && !recl_inh_r) || (rem_ok && (scr_set
             || (cmd_wr && wd[pcl_pkg::CMD_RECL_SET])))) begin
            recl_inh_r <= 1'b1;
         end else if ((edit_take && recl_p) || (rem_ok && (scr_clr
             || (cmd_wr && wd[pcl_pkg::CMD_RECL_CLR])))) begin
            recl_inh_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         remote_lockout <= 1'b0;
      end else if (ce && edit_take && reml_p) begin
         remote_lockout <= ~remote_lockout;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         active_group <= pcl_pkg::PROF_NORMAL;
      end else if (ce) begin
         if (edit_take && prof_p != 3'h0) begin
            for (int k = 0; k < 3; k++) begin
               if (prof_p[k] && (prof_p & ~(3'h7 << k)) == 3'h0) begin
                  active_group <= (active_group == 2'(k + 1)) ? pcl_pkg::PROF_NORMAL : 2'(k + 1);
               end
            end
         end else if (rem_ok && cmd_wr && wd[pcl_pkg::CMD_PROF_WR]) begin
            active_group <= wd[pcl_pkg::CMD_PROF_LSB +: 2];
         end
      end
   end

   // close handling
   logic clf_alarm_r, pend_r, clf_busy, clf_done, inrush_r;
   logic close_req, close_blk, fire, pend_fire;
   assign close_req = close_p | (rem_ok & (sc_close_p | (cmd_wr & wd[pcl_pkg::CMD_CLOSE])));
   assign close_blk = live_on | clf_alarm_r;
   assign fire = close_req & ~close_blk & ilock_s & ~pend_r;
   // restored interlock completes the pending close
   assign pend_fire = pend_r & ilock_s & ~close_blk;

   pcl_timer #(.LEN(CLFAIL_CYC)) u_clf (
      .clk(clk), .rst_n(rst_n), .ce(ce),
      .start(close_req & ~close_blk & ~ilock_s & ~pend_r),
      .stop(pend_fire | (pend_r & close_blk)), .busy(clf_busy), .done(clf_done)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_r <= 1'b0;
      end else if (ce) begin
         if (close_req && !close_blk && !ilock_s) begin
            pend_r <= 1'b1;
         end else if (pend_fire || clf_done || close_blk) begin
            pend_r <= 1'b0;
         end
      end
   end

   // alarm when the wait runs out; a new alarm wins over a clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clf_alarm_r <= 1'b0;
      end else if (ce) begin
         if (clf_done && pend_r) begin
            clf_alarm_r <= 1'b1;
         end else if (alm_wr && wd[pcl_pkg::ALM_CLFAIL]) begin
            clf_alarm_r <= 1'b0;
         end
      end
   end

   // trip from the button also runs while software is dead
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trip_cmd <= 1'b0;
         close_cmd <= 1'b0;
         seq_home <= 1'b0;
         lockout <= 1'b1;
      end else if (ce) begin
         trip_cmd <= trip_p;
         close_cmd <= (fire | pend_fire) & ~trip_p;
         seq_home <= (fire | pend_fire) & ~trip_p;
         if (trip_p) begin
            lockout <= 1'b1;
         end else if (fire || pend_fire) begin
            lockout <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         inrush_r <= 1'b0;
      end else if (ce) begin
         if (trip_p) begin
            inrush_r <= 1'b0;
         end else if ((fire || pend_fire) && lockout && !brk_s && ctrl_r[pcl_pkg::CTRL_INRUSH_EN]
                      && !ctrl_r[pcl_pkg::CTRL_INRUSH_BLK]) begin
            inrush_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         one_trip_lockout <= 1'b0;
         composite_curve <= 1'b0;
         inrush_restraint_protection <= 1'b0;
         reclose_block <= 1'b0;
         fast_trip_disable <= 1'b0;
      end else if (ce) begin
         one_trip_lockout <= live_on;
         composite_curve <= live_on;
         inrush_restraint_protection <= inrush_r & ~live_on;
         reclose_block <= recl_inh_r | live_on;
         fast_trip_disable <= ctrl_r[pcl_pkg::CTRL_FASTDIS] & ~live_on;
      end
   end

   // idle timer restarted by any panel operation
   logic blank_busy, blank_done, blank_r, panel_op;
   assign panel_op = ed_p | fkey | close_p | trip_p | (s2_r[0] ^ s3_r[0]);
   pcl_timer #(.LEN(BLANK_CYC)) u_blank (
      .clk(clk), .rst_n(rst_n), .ce(ce), .start(panel_op | (~blank_busy & ~blank_r)), .stop(1'b0),
      .busy(blank_busy), .done(blank_done)
   );
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         blank_r <= 1'b0;
      end else if (ce) begin
         blank_r <= (blank_r | blank_done) & ~panel_op & ctrl_r[pcl_pkg::CTRL_PWRSAVE];
      end
   end

   // LEDs follow state, not the source
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         led_live <= 1'b0;
         led_earth <= 1'b0;
         led_recl <= 1'b0;
         led_remlock <= 1'b0;
         led_prof <= 3'h0;
         led_alarm <= 1'b0;
         led_lockout <= 1'b0;
      end else if (ce) begin
         led_live <= live_on;
         led_earth <= earth_block & ~blank_r;
         led_recl <= recl_inh_r & ~blank_r;
         led_remlock <= remote_lockout & ~blank_r;
         for (int k = 0; k < 3; k++) begin
            led_prof[k] <= (active_group == 2'(k + 1)) & ~blank_r;
         end
         led_alarm <= clf_alarm_r & ~blank_r;
         led_lockout <= lockout & ~blank_r;
      end
   end

   // read data captured in the wait cycle
   logic [31:0] st;
   always_comb begin
      st = 32'h0;
      st[pcl_pkg::ST_LIVE] = live_on;
      st[pcl_pkg::ST_REQ_LSB +: 3] = {req_scada_r, req_serial_r, req_panel};
      st[pcl_pkg::ST_EARTH] = earth_block;
      st[pcl_pkg::ST_RECL] = recl_inh_r;
      st[pcl_pkg::ST_REMLK] = remote_lockout;
      st[pcl_pkg::ST_PROF_LSB +: 2] = active_group;
      st[pcl_pkg::ST_CLFAIL] = clf_alarm_r;
      st[pcl_pkg::ST_LOCKOUT] = lockout;
      st[pcl_pkg::ST_BRK] = brk_s;
      st[pcl_pkg::ST_EDIT] = edit_busy;
      st[pcl_pkg::ST_INRUSH] = inrush_r;
      st[pcl_pkg::ST_PEND] = pend_r;
      st[pcl_pkg::ST_BLANK] = blank_r;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= 32'h0;
      end else if (ce && acc && avs_read) begin
         case (avs_address)
            pcl_pkg::OFS_CTRL: avs_readdata <= {28'h0, ctrl_r};
            pcl_pkg::OFS_STATUS: avs_readdata <= st;
            pcl_pkg::OFS_ALARM: avs_readdata <= {31'h0, clf_alarm_r};
            default: avs_readdata <= 32'h0;
         endcase
      end
   end

   logic unused_ok;
   assign unused_ok = edit_done | clf_busy;
endmodule // pcl_panel

// >>> verif/pcl_checker.sv
/* pcl_checker: port assertions for pcl_panel, bound at the foot.
   assumes one clock domain and the top module's resetn. */
`timescale 1ns/1ns
module pcl_checker (
   input wire logic clk,
   input wire logic resetn,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic interlock_in,
   input wire logic close_cmd,
   input wire logic trip_cmd,
   input wire logic seq_home,
   input wire logic lockout,
   input wire logic one_trip_lockout,
   input wire logic composite_curve,
   input wire logic inrush_restraint_protection,
   input wire logic reclose_block,
   input wire logic fast_trip_disable,
   input wire logic [2:0] led_prof
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_inhibit_no_close: assert property (one_trip_lockout && $past(one_trip_lockout) |-> !close_cmd)
      else $error("close while inhibited");
   a_arm_no_trip: assert property ($rose(one_trip_lockout) |-> (!trip_cmd)[*4])
      else $error("trip on inhibit");
   a_curve_follows: assert property (one_trip_lockout == composite_curve)
      else $error("curve mismatch");
   a_inhibit_rank: assert property (one_trip_lockout |-> reclose_block
      && !inrush_restraint_protection && !fast_trip_disable)
      else $error("inhibit precedence");
   a_interlock_out: assert property ((!interlock_in)[*6] |-> !close_cmd)
      else $error("close with interlock out");
   a_trip_locks: assert property (trip_cmd |-> ##[0:1] lockout)
      else $error("trip without lockout");
   a_close_homes: assert property (close_cmd |-> seq_home)
      else $error("close without home");
   a_group_onehot: assert property ($onehot0(led_prof))
      else $error("two groups lit");
   a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
   c_close: cover property (close_cmd);
   c_trip: cover property (trip_cmd);
   c_inhibit: cover property ($rose(one_trip_lockout));
endmodule // pcl_checker
bind pcl_panel pcl_checker pcl_checker_i (.clk(clk), .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .interlock_in(interlock_in), .close_cmd(close_cmd), .trip_cmd(trip_cmd),
   .seq_home(seq_home), .lockout(lockout), .one_trip_lockout(one_trip_lockout), .composite_curve(composite_curve),
   .inrush_restraint_protection(inrush_restraint_protection), .reclose_block(reclose_block),
   .fast_trip_disable(fast_trip_disable), .led_prof(led_prof));

// >>> verif/pcl_operator.sv
/* pcl_operator: panel operator, supervisory contacts and breaker mechanism.
   assumes the bench calls its tasks just after a rising edge. */
`timescale 1ns/1ns
module pcl_operator (
   input wire logic clk,
   input wire logic close_cmd,
   input wire logic trip_cmd,
   output logic [17:0] pins,
   output logic breaker_closed
);
   // interlock fitted, all keys released
   initial begin
      pins = 18'h20000;
      breaker_closed = 1'b0;
   end
   always @(posedge clk) begin
      if (trip_cmd) begin
         breaker_closed <= 1'b0;
      end else if (close_cmd) begin
         breaker_closed <= 1'b1;
      end
   end
   // held long enough to pass the input synchronisers
   task automatic set_pin(input int k, input logic v);
      pins[k] <= v;
      repeat (6) @(posedge clk);
   endtask
   task automatic press(input int k);
      set_pin(k, 1'b1);
      set_pin(k, 1'b0);
   endtask
   task automatic change(input int k);
      press(1);
      press(k);
   endtask
endmodule // pcl_operator

// >>> verif/pcl_panel_bench.sv
/* pcl_panel_bench: self-checking bench for pcl_panel.
   assumes pcl_operator as panel, contacts and breaker. */
`timescale 1ns/1ns
module pcl_panel_bench;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest, close_cmd, trip_cmd, lockout, inrush, led_live, led_alarm, led_lockout, brk;
   logic [17:0] pins;
   logic [14:0] o;
   int errors = 0;
   int tests_run = 0;
   // edit, pin, status mask, expected
   logic [15:0] rows [18][4] = '{'{1, 2, 16'h10, 16'h10}, '{1, 2, 16'h10, 16'h0}, '{0, 12, 16'h10, 16'h10},
      '{0, 13, 16'h10, 16'h0}, '{1, 3, 16'h20, 16'h20}, '{0, 15, 16'h20, 16'h0}, '{0, 3, 16'h20, 16'h0},
      '{0, 14, 16'h20, 16'h20}, '{1, 3, 16'h20, 16'h0}, '{1, 6, 16'h180, 16'h100}, '{1, 6, 16'h180, 16'h0},
      '{1, 7, 16'h180, 16'h180}, '{1, 5, 16'h180, 16'h80}, '{1, 4, 16'h40, 16'h40}, '{0, 12, 16'h10, 16'h0},
      '{0, 10, 16'h1, 16'h1}, '{0, 11, 16'h1, 16'h0}, '{1, 4, 16'h40, 16'h0}};
   // short counts keep the run brief
   pcl_panel #(.EDIT_CYC(64'd50), .BLANK_CYC(64'd3000), .CLFAIL_CYC(64'd40)) pcl_panel_i (
      .clk(clk), .resetn(resetn), .ce(1'b1), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .live_switch(pins[0]), .edit_key(pins[1]), .earth_key(pins[2]),
      .recl_key(pins[3]), .remlock_key(pins[4]), .prof_key(pins[7:5]), .close_btn(pins[8]), .trip_btn(pins[9]),
      .sc_live_set(pins[10]), .sc_live_clr(pins[11]), .sc_earth_set(pins[12]), .sc_earth_clr(pins[13]),
      .sc_recl_set(pins[14]), .sc_recl_clr(pins[15]), .sc_close(pins[16]), .interlock_in(pins[17]),
      .breaker_closed(brk), .close_cmd(close_cmd), .trip_cmd(trip_cmd), .seq_home(o[0]), .lockout(lockout),
      .one_trip_lockout(o[1]), .composite_curve(o[2]), .inrush_restraint_protection(inrush), .reclose_block(o[3]),
      .fast_trip_disable(o[4]), .earth_block(o[5]), .active_group(o[7:6]), .remote_lockout(o[8]),
      .led_live(led_live), .led_earth(o[9]), .led_recl(o[10]), .led_remlock(o[11]), .led_prof(o[14:12]),
      .led_alarm(led_alarm), .led_lockout(led_lockout));
   pcl_operator pcl_operator_i (.clk(clk), .close_cmd(close_cmd), .trip_cmd(trip_cmd), .pins(pins),
      .breaker_closed(brk));
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         errors++;
         give_verdict();
      end
      @(posedge clk);
   endtask
   initial begin
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      repeat (5) @(posedge clk);
      bus(1'b0, 4'h0, 32'h0, q);
      check(q[15:0], 16'h3);
      bus(1'b0, 4'h2, 32'h0, q);
      check(q[15:0], 16'h0);
      $display("registers done");
      for (int i = 0; i < 18; i++) begin
         if (rows[i][0] == 16'h1) begin
            pcl_operator_i.change(rows[i][1]);
         end else begin
            pcl_operator_i.press(rows[i][1]);
         end
         bus(1'b0, 4'h8, 32'h0, q);
         check(q[15:0] & rows[i][2], rows[i][3]);
      end
      check({1'b0, o}, 16'h1040);
      $display("function keys done");
      bus(1'b1, 4'h0, 32'hB, q);
      pcl_operator_i.press(8);
      check({13'h0, brk, lockout, inrush}, 16'h5);
      pcl_operator_i.set_pin(0, 1'b1);
      bus(1'b1, 4'h4, 32'h1, q);
      pcl_operator_i.press(11);
      pcl_operator_i.set_pin(0, 1'b0);
      bus(1'b0, 4'h8, 32'h0, q);
      check(q[15:0] & 16'hF, 16'h5);
      check({13'h0, brk, led_live, inrush}, 16'h6);
      check({1'b0, o} & 16'h1F, 16'hE);
      pcl_operator_i.press(9);
      check({14'h0, brk, lockout}, 16'h1);
      pcl_operator_i.press(8);
      pcl_operator_i.press(16);
      check({15'h0, brk}, 16'h0);
      repeat (3100) @(posedge clk);
      check({14'h0, led_live, led_lockout}, 16'h2);
      bus(1'b1, 4'h4, 32'h2, q);
      bus(1'b0, 4'h8, 32'h0, q);
      check(q[15:0] & 16'hF, 16'h0);
      check({15'h0, o[4]}, 16'h1);
      $display("inhibit done");
      pcl_operator_i.set_pin(17, 1'b0);
      pcl_operator_i.press(8);
      repeat (45) @(posedge clk);
      check({14'h0, brk, led_alarm}, 16'h1);
      pcl_operator_i.set_pin(17, 1'b1);
      pcl_operator_i.press(8);
      check({15'h0, brk}, 16'h0);
      bus(1'b1, 4'hC, 32'h1, q);
      pcl_operator_i.press(8);
      check({15'h0, brk}, 16'h1);
      pcl_operator_i.press(9);
      pcl_operator_i.set_pin(17, 1'b0);
      pcl_operator_i.press(8);
      pcl_operator_i.set_pin(17, 1'b1);
      check({15'h0, brk}, 16'h1);
      $display("interlock done");
      pcl_operator_i.press(1);
      repeat (60) @(posedge clk);
      pcl_operator_i.press(2);
      bus(1'b0, 4'h8, 32'h0, q);
      check(q[15:0] & 16'h10, 16'h0);
      $display("edit expiry done");
      give_verdict();
   end
endmodule // pcl_panel_bench
